/* File: core/mpf_defines.svh */
// Purpose: Register offsets, field positions, reset values and key constants
// Assumes: Classic Wishbone, 32-bit data, byte addresses
// Notes:   Included by the PWM core and the testbench
`ifndef MPF_DEFINES_SVH
`define MPF_DEFINES_SVH

`define MPF_ADDR_W           8
`define MPF_OFF_CTRL         8'h00
`define MPF_OFF_KEY          8'h04
`define MPF_OFF_MTPER        8'h08
`define MPF_OFF_SEVCMP       8'h0C
`define MPF_OFF_STATUS       8'h10
`define MPF_OFF_GEN_BASE     8'h20
`define MPF_GEN_STRIDE       8'h20
`define MPF_GOFF_PER         8'h00
`define MPF_GOFF_DUTY        8'h04
`define MPF_GOFF_PHASE       8'h08
`define MPF_GOFF_TRIG        8'h0C
`define MPF_GOFF_OUTCTL      8'h10
`define MPF_GOFF_FLTCTL      8'h14

`define MPF_KEY_FIRST        16'hABCD
`define MPF_KEY_SECOND       16'h4321

// Control register fields
`define MPF_CTRL_EN          0
`define MPF_CTRL_SYNCEN      1
`define MPF_CTRL_SYNCOEN     2
`define MPF_CTRL_LOCK        6
`define MPF_CTRL_SEVSRC      7
`define MPF_CTRL_RESET       32'h0000_0040

// Output control fields
`define MPF_OC_HEN           0
`define MPF_OC_LEN           1
`define MPF_OC_SWAP          2
`define MPF_OC_SAFEH         3
`define MPF_OC_SAFEL         4

// Fault control fields: mode at 1:0, source select above
`define MPF_FC_MODE_LSB      0
`define MPF_FC_SRC_LSB       2
`define MPF_FC_RESET         32'h0000_0010
`define MPF_FM_LATCHED       2'h0
`define MPF_FM_CYCLE         2'h1
`define MPF_FM_OFF           2'h3

`define MPF_PER_RESET        16'hFFF8
`define MPF_TICK_NS          10'd0100
`define MPF_RES_PS           16'h2080
`endif

/* File: core/mpf_pkg.sv */
// Purpose: Types shared by the PWM block
// Assumes: mpf_defines.svh supplies constants
// Notes:   Fault vector: a, b, c, d, safety in bits 0..4
package mpf_pkg;
	typedef struct packed {
		logic [2:0] high;
		logic [2:0] low;
	} mpf_pins_type;
	typedef enum logic [1:0] {
		MPF_K_IDLE,
		MPF_K_GOT1,
		MPF_K_OPEN
	} mpf_key_type;
endpackage : mpf_pkg

/* File: core/mpf_pwm.sv */
// Purpose: Three-generator complementary PWM with fault latch and key lock
// Assumes: 10 MHz clock, synchronous active-high reset, classic Wishbone slave
// Notes:   One count per clock; resolution is the clock period here
`include "mpf_defines.svh"

// Contract
// - Six outputs from three generators
// - Each generator drives high and low pin
// - Timing resolution one counter tick
// - Master time base aligns all generators
// - Enabled asserted fault forces safe state
// - Per-generator converter trigger at programmed count
// - Special trigger from master or generator 0 base, selectable
// - Sync input aligns base; sync output pulses
// - Four external faults plus safety fault
// - Safety fault latched enabled out of reset
// - Latched safety clear only when pin low
// - Fault mode bits always writable
// - Lock bit blocks protected register writes
// - Keys ABCD then 4321 open lock
// - Protected write must be next access
// - One unlock permits one protected write
// - Per-generator period, duty, phase
// - High and low pins swappable
module mpf_pwm #(
	parameter int NGEN = 3
) (
	input  wire logic                CLK,        // 10 MHz clock
	input  wire logic                SRST,       // Sync reset, high
	input  wire logic [31:0]         WB_ADR_I,   // Byte address
	input  wire logic [31:0]         WB_DAT_I,   // Write data
	output logic      [31:0]         WB_DAT_O,   // Read data
	input  wire logic                WB_WE_I,    // Write enable
	input  wire logic [3:0]          WB_SEL_I,   // Byte lanes
	input  wire logic                WB_STB_I,   // Strobe
	input  wire logic                WB_CYC_I,   // Cycle
	output logic                     WB_ACK_O,   // Acknowledge
	input  wire logic                EXT_SYNC_INPUT,   // Sync pin in
	input  wire logic [3:0]          FAULT_INPUT,      // Faults a..d
	input  wire logic                SAFETY_FAULT_INPUT, // Safety pin
	output mpf_pkg::mpf_pins_type    PWM_OUT,    // High/low pins
	output logic [2:0]               ADC_TRIG,   // Per-gen trigger
	output logic                     ADC_SEV_TRIG, // Special trigger
	output logic                     EXT_SYNC_OUTPUT // Sync pin out
);
	import mpf_pkg::*;

	if (NGEN != 3) begin : g_ngen_check
		$error("NGEN must be 3");
	end

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
		for (int i = 0; i < 4; i++) begin
			merge[i*8 +: 8] = sel[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
		end
	endfunction : merge

	// Pin synchronisers
	logic [5:0] sync_a;
	logic [5:0] sync_b;
	always_ff @(posedge CLK) begin
		sync_a <= {SAFETY_FAULT_INPUT, FAULT_INPUT, EXT_SYNC_INPUT};
		sync_b <= sync_a;
	end
	wire       sync_in  = sync_b[0];
	wire [4:0] flt_pins = sync_b[5:1];
	logic sync_prev;

	// Registers
	logic [31:0] ctrl;
	logic [15:0] mtper;
	logic [15:0] sevcmp;
	logic [15:0] per   [3];
	logic [15:0] duty  [3];
	logic [15:0] phase [3];
	logic [15:0] trig  [3];
	logic [31:0] outctl [3];
	logic [31:0] fltctl [3];
	logic [2:0]  flt_latch;
	logic        safety_latch;
	mpf_key_type key_state;
	logic [15:0] mtmr;
	logic [15:0] gtmr [3];

	// Bus decode
	wire        req     = WB_CYC_I && WB_STB_I && !WB_ACK_O;
	wire [7:0]  adr     = WB_ADR_I[7:0];
	wire        wr      = req && WB_WE_I;
	wire        in_gen  = adr >= `MPF_OFF_GEN_BASE && adr < `MPF_OFF_GEN_BASE + 3 * `MPF_GEN_STRIDE;
	wire [7:0]  gofs    = adr - `MPF_OFF_GEN_BASE;
	wire [1:0]  gsel    = gofs[6:5];
	wire [7:0]  greg    = {3'h0, gofs[4:0]};
	wire        hit_key = wr && adr == `MPF_OFF_KEY;
	wire        hit_oc  = in_gen && greg == `MPF_GOFF_OUTCTL;
	wire        hit_fc  = in_gen && greg == `MPF_GOFF_FLTCTL;
	wire        hit_ctrl   = adr == `MPF_OFF_CTRL;
	wire        hit_mtper  = adr == `MPF_OFF_MTPER;
	wire        hit_sevcmp = adr == `MPF_OFF_SEVCMP;
	wire        hit_status = adr == `MPF_OFF_STATUS;
	wire        hit_gen    = in_gen && gsel < 2'd3;
	wire        hit_per    = hit_gen && greg == `MPF_GOFF_PER;
	wire        hit_duty   = hit_gen && greg == `MPF_GOFF_DUTY;
	wire        hit_phase  = hit_gen && greg == `MPF_GOFF_PHASE;
	wire        hit_trig   = hit_gen && greg == `MPF_GOFF_TRIG;
	wire        rd_en      = req && !WB_WE_I;
	wire        locked  = ctrl[`MPF_CTRL_LOCK];
	wire        prot_ok = !locked || key_state == MPF_K_OPEN;
	wire [31:0] wdat    = WB_DAT_I;
	wire        key_first  = hit_key && wdat[15:0] == `MPF_KEY_FIRST;
	wire        key_second = hit_key && wdat[15:0] == `MPF_KEY_SECOND;

	// key sequence, a repeated first key holds it, any other access resets it
	mpf_key_type next_key_state;
	always_comb begin
		next_key_state = key_state;
		if (req) begin
			case (key_state)
				MPF_K_IDLE: next_key_state = key_first ? MPF_K_GOT1 : MPF_K_IDLE;
				MPF_K_GOT1: next_key_state = key_second ? MPF_K_OPEN : (key_first ? MPF_K_GOT1 : MPF_K_IDLE);
				MPF_K_OPEN: next_key_state = MPF_K_IDLE;
				default:    next_key_state = MPF_K_IDLE;
			endcase
		end
	end

	// Fault sources per generator
	logic [2:0] flt_now;
	logic [2:0] safe;
	logic [2:0] new_period;
	always_comb begin
		for (int g = 0; g < 3; g++) begin
			flt_now[g] = fltctl[g][`MPF_FC_SRC_LSB +: 3] < 3'd5 && flt_pins[fltctl[g][`MPF_FC_SRC_LSB +: 3]];
			new_period[g] = gtmr[g] >= per[g];
			// safe state on active or latched fault
			safe[g] = fltctl[g][1:0] != `MPF_FM_OFF && (flt_now[g] || flt_latch[g]);
		end
	end

	// Latched safety clear needs the pin low
	wire safety_low = !flt_pins[4];
	wire clr_write  = wr && hit_status;
	// clear refused while the pin is high
	wire safety_clr = clr_write && wdat[3] && safety_low;

	// safety fault owned and latched through reset; set wins
	always_ff @(posedge CLK) begin
		if (SRST) begin
			safety_latch <= 1'b1;
		end else if (flt_pins[4]) begin
			safety_latch <= 1'b1;
		end else if (safety_clr) begin
			safety_latch <= 1'b0;
		end
	end

	always_ff @(posedge CLK) begin
		if (SRST) begin
			key_state <= MPF_K_IDLE;
		end else begin
			key_state <= next_key_state;
		end
	end

	// Global registers; the lock bit lives in ctrl
	always_ff @(posedge CLK) begin
		if (SRST) begin
			ctrl   <= `MPF_CTRL_RESET;
			mtper  <= `MPF_PER_RESET;
			sevcmp <= 16'h0000;
		end else if (wr) begin
			if (hit_ctrl) begin
				ctrl <= merge(ctrl, wdat, WB_SEL_I);
			end else if (hit_mtper) begin
				mtper <= wdat[15:0];
			end else if (hit_sevcmp) begin
				sevcmp <= wdat[15:0];
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (SRST) begin
			for (int g = 0; g < 3; g++) begin
				per[g]   <= `MPF_PER_RESET;
				duty[g]  <= 16'h0000;
				phase[g] <= 16'h0000;
				trig[g]  <= 16'h0000;
			end
		end else if (wr) begin
			if (hit_per) begin
				per[gsel] <= wdat[15:0];
			end
			if (hit_duty) begin
				duty[gsel] <= wdat[15:0];
			end
			if (hit_phase) begin
				phase[gsel] <= wdat[15:0];
			end
			if (hit_trig) begin
				trig[gsel] <= wdat[15:0];
			end
		end
	end

	// protected registers, one write per unlock
	always_ff @(posedge CLK) begin
		if (SRST) begin
			for (int g = 0; g < 3; g++) begin
				outctl[g] <= 32'h0000_0000;
				fltctl[g] <= `MPF_FC_RESET;
			end
		end else if (wr && hit_gen) begin
			if (hit_oc && prot_ok) begin
				outctl[gsel] <= merge(outctl[gsel], wdat, WB_SEL_I);
			end
			if (hit_fc && prot_ok) begin
				fltctl[gsel] <= merge(fltctl[gsel], wdat, WB_SEL_I);
			end else if (hit_fc && WB_SEL_I[0]) begin
				// mode bits stay writable under lock
				fltctl[gsel][1:0] <= wdat[1:0];
			end
		end
	end

	// Read data selection; unmapped addresses read zero
	logic [31:0] rd_data;
	always_comb begin
		rd_data = 32'h0000_0000;
		if (hit_ctrl) begin
			rd_data = ctrl;
		end else if (hit_mtper) begin
			rd_data = {16'h0000, mtper};
		end else if (hit_sevcmp) begin
			rd_data = {16'h0000, sevcmp};
		end else if (hit_status) begin
			rd_data = {26'h0, key_state == MPF_K_OPEN, safety_latch, flt_pins[4], flt_latch};
		end else if (hit_per) begin
			rd_data = {16'h0000, per[gsel]};
		end else if (hit_duty) begin
			rd_data = {16'h0000, duty[gsel]};
		end else if (hit_phase) begin
			rd_data = {16'h0000, phase[gsel]};
		end else if (hit_trig) begin
			rd_data = {16'h0000, trig[gsel]};
		end else if (hit_oc) begin
			rd_data = outctl[gsel];
		end else if (hit_fc) begin
			rd_data = fltctl[gsel];
		end
	end

	// Latched faults per generator
	always_ff @(posedge CLK) begin
		if (SRST) begin
			flt_latch <= 3'b111;
		end else begin
			for (int g = 0; g < 3; g++) begin
				if (flt_now[g] && fltctl[g][1:0] != `MPF_FM_OFF) begin
					flt_latch[g] <= 1'b1;
				end else if (fltctl[g][1:0] == `MPF_FM_CYCLE && new_period[g]) begin
					flt_latch[g] <= 1'b0;
				end else if (wr && adr == `MPF_OFF_STATUS && wdat[g] &&
						!(fltctl[g][`MPF_FC_SRC_LSB +: 3] == 3'd4 && !safety_low)) begin
					flt_latch[g] <= 1'b0;
				end
			end
		end
	end

	// master time base with external sync
	wire ext_sync_edge = ctrl[`MPF_CTRL_SYNCEN] && sync_in && !sync_prev;
	wire mt_wrap = mtmr >= mtper || ext_sync_edge;
	always_ff @(posedge CLK) begin
		if (SRST) begin
			mtmr      <= 16'h0000;
			sync_prev <= 1'b0;
			for (int g = 0; g < 3; g++) gtmr[g] <= 16'h0000;
		end else begin
			sync_prev <= sync_in;
			if (!ctrl[`MPF_CTRL_EN]) begin
				mtmr <= 16'h0000;
				for (int g = 0; g < 3; g++) gtmr[g] <= phase[g];
			end else begin
				mtmr <= mt_wrap ? 16'h0000 : mtmr + 16'h0001;
				for (int g = 0; g < 3; g++) begin
					if (mt_wrap) gtmr[g] <= phase[g];
					else gtmr[g] <= new_period[g] ? 16'h0000 : gtmr[g] + 16'h0001;
				end
			end
		end
	end

	logic [2:0] next_high;
	logic [2:0] next_low;
	always_comb begin
		next_high = 3'b000;
		next_low  = 3'b000;
		for (int g = 0; g < 3; g++) begin
			if (!ctrl[`MPF_CTRL_EN] || safe[g] || safety_latch) begin
				next_high[g] = outctl[g][`MPF_OC_SAFEH];
				next_low[g]  = outctl[g][`MPF_OC_SAFEL];
			end else if (outctl[g][`MPF_OC_SWAP]) begin
				next_high[g] = outctl[g][`MPF_OC_HEN] && gtmr[g] >= duty[g];
				next_low[g]  = outctl[g][`MPF_OC_LEN] && gtmr[g] < duty[g];
			end else begin
				next_high[g] = outctl[g][`MPF_OC_HEN] && gtmr[g] < duty[g];
				next_low[g]  = outctl[g][`MPF_OC_LEN] && gtmr[g] >= duty[g];
			end
		end
	end

	// trigger at programmed count; faults do not mask it
	logic [2:0] next_trig;
	always_comb begin
		next_trig = 3'b000;
		for (int g = 0; g < 3; g++) begin
			next_trig[g] = ctrl[`MPF_CTRL_EN] && gtmr[g] == trig[g];
		end
	end
	// special trigger from master or generator 0 base
	wire [15:0] sev_base      = ctrl[`MPF_CTRL_SEVSRC] ? gtmr[0] : mtmr;
	wire        next_sev      = ctrl[`MPF_CTRL_EN] && sev_base == sevcmp;
	wire        next_sync_out = ctrl[`MPF_CTRL_EN] && ctrl[`MPF_CTRL_SYNCOEN] && mt_wrap;

	// Bus response: ack and data stand one cycle
	always_ff @(posedge CLK) begin
		if (SRST) begin
			WB_ACK_O <= 1'b0;
			WB_DAT_O <= 32'h0000_0000;
		end else begin
			WB_ACK_O <= req;
			WB_DAT_O <= rd_en ? rd_data : 32'h0000_0000;
		end
	end

	// Pins and pulses, all registered
	always_ff @(posedge CLK) begin
		if (SRST) begin
			PWM_OUT         <= '0;
			ADC_TRIG        <= 3'b000;
			ADC_SEV_TRIG    <= 1'b0;
			EXT_SYNC_OUTPUT <= 1'b0;
		end else begin
			PWM_OUT.high    <= next_high;
			PWM_OUT.low     <= next_low;
			ADC_TRIG        <= next_trig;
			ADC_SEV_TRIG    <= next_sev;
			EXT_SYNC_OUTPUT <= next_sync_out;
		end
	end
endmodule : mpf_pwm

/* File: verification/mpf_pwm_assertions.sv */
// Purpose: Port-level checks for mpf_pwm
// Assumes: Ack one cycle after take, outputs 0 in reset
// Notes:   Bound to every mpf_pwm instance
module mpf_pwm_chk #(
	parameter int NGEN = 3
) (
	input wire logic                  CLK,             // Clock
	input wire logic                  SRST,            // Reset
	input wire logic                  WB_CYC_I,        // Cycle
	input wire logic                  WB_STB_I,        // Strobe
	input wire logic                  WB_WE_I,         // Write
	input wire logic                  WB_ACK_O,        // Ack
	input wire mpf_pkg::mpf_pins_type PWM_OUT,         // Pins
	input wire logic [2:0]            ADC_TRIG,        // Triggers
	input wire logic                  ADC_SEV_TRIG,    // Special
	input wire logic                  EXT_SYNC_OUTPUT  // Sync out
);
	timeunit 1ns;
	timeprecision 1ns;
	import mpf_pkg::*;
	logic wr_seen;
	default clocking dc @(posedge CLK); endclocking
	default disable iff (SRST);
	// Set once software has written anything
	always_ff @(posedge CLK) begin
		if (SRST) wr_seen <= 1'b0;
		else if (WB_CYC_I && WB_STB_I && WB_WE_I) wr_seen <= 1'b1;
	end
	a_ack_after_take: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
		else $error("no ack after request");
	a_ack_one_cycle: assert property (WB_ACK_O |=> !WB_ACK_O)
		else $error("ack held too long");
	a_ack_needs_req: assert property (!(WB_CYC_I && WB_STB_I) |=> !WB_ACK_O)
		else $error("ack without request");
	a_reset_quiet: assert property (disable iff (1'b0) SRST |=> PWM_OUT == 6'h00 && !WB_ACK_O)
		else $error("outputs active after reset");
	a_boot_safe: assert property (!wr_seen |-> PWM_OUT == 6'h00)
		else $error("pins left safe state");
	a_trig_pulse: assert property (|ADC_TRIG |=> (ADC_TRIG & $past(ADC_TRIG)) == 3'h0)
		else $error("trigger longer than one cycle");
	a_sev_pulse: assert property ($rose(ADC_SEV_TRIG) |=> $fell(ADC_SEV_TRIG))
		else $error("special trigger too long");
	a_sync_pulse: assert property (EXT_SYNC_OUTPUT |=> !EXT_SYNC_OUTPUT)
		else $error("sync out too long");
endmodule : mpf_pwm_chk
bind mpf_pwm mpf_pwm_chk #(.NGEN(NGEN)) u_chk (.CLK(CLK), .SRST(SRST), .WB_CYC_I(WB_CYC_I),
	.WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ACK_O(WB_ACK_O), .PWM_OUT(PWM_OUT),
	.ADC_TRIG(ADC_TRIG), .ADC_SEV_TRIG(ADC_SEV_TRIG), .EXT_SYNC_OUTPUT(EXT_SYNC_OUTPUT));

/* File: verification/mpf_far_side.sv */
// Purpose: Fault source and gate driver model
// Assumes: Safety pin carries a pull-down
// Notes:   Counts gen0 high-side rising edges
module mpf_far_side (
	input  wire logic                  clk,    // Clock
	input  wire mpf_pkg::mpf_pins_type pins,   // Gate drive
	input  wire logic                  trip,   // Hold safety high
	output logic                       safety, // Safety pin
	output int                         rises   // Gen0 edges
);
	timeunit 1ns;
	timeprecision 1ns;
	import mpf_pkg::*;
	logic hi_q = 1'b0;
	int   cnt = 0;
	assign safety = trip;
	assign rises = cnt;
	always @(posedge clk) begin
		hi_q <= pins.high[0];
		if (pins.high[0] && !hi_q) begin
			cnt <= cnt + 1;
		end
	end
endmodule : mpf_far_side

/* File: verification/tb.sv */
// Purpose: Bus-level bench for mpf_pwm
// Assumes: Ack one cycle after take
// Notes:   Safe pin levels are 0 at reset
`include "mpf_defines.svh"
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import mpf_pkg::*;
	localparam logic [7:0]  STA = `MPF_OFF_STATUS;
	localparam logic [7:0]  KEY = `MPF_OFF_KEY;
	localparam logic [7:0]  G0  = `MPF_OFF_GEN_BASE;
	localparam logic [7:0]  OC0 = G0 + `MPF_GOFF_OUTCTL;
	localparam logic [7:0]  FC0 = G0 + `MPF_GOFF_FLTCTL;
	localparam logic [31:0] ALL = 32'hFFFF_FFFF;
	logic         clk = 1'b0, srst = 1'b1, we = 1'b0, stb = 1'b0, cyc = 1'b0;
	logic         ack, trip = 1'b1, sync_req = 1'b0, safety, sev, sync_out;
	logic [31:0]  adr = 32'h0000_0000, dat = 32'h0000_0000, q, dat_o;
	logic [3:0]   flt = 4'h0;
	logic [2:0]   trig;
	logic [1:0]   acc, ph;
	mpf_pins_type pins;
	int           rises, nt = 0, n1 = 0, nv = 0, ns = 0, err_total = 0, checks = 0;
	always #50 clk = ~clk;
	mpf_pwm #(.NGEN(3)) DUT (.CLK(clk), .SRST(srst), .WB_ADR_I(adr), .WB_DAT_I(dat), .WB_DAT_O(dat_o),
		.WB_WE_I(we), .WB_SEL_I(4'hF), .WB_STB_I(stb), .WB_CYC_I(cyc), .WB_ACK_O(ack),
		.EXT_SYNC_INPUT(sync_req), .FAULT_INPUT(flt), .SAFETY_FAULT_INPUT(safety), .PWM_OUT(pins),
		.ADC_TRIG(trig), .ADC_SEV_TRIG(sev), .EXT_SYNC_OUTPUT(sync_out));
	mpf_far_side u_far (.clk(clk), .pins(pins), .trip(trip), .safety(safety), .rises(rises));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %0t got %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n;
		n = 0;
		adr <= {24'h00_0000, a};
		we <= w;
		dat <= d;
		cyc <= 1'b1;
		stb <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 16);
		q = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
		if (n >= 16) chk(32'(ack), 32'h0000_0001);
	endtask : wb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wb(a, 1'b1, d);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		wb(a, 1'b0, 32'h0000_0000);
		chk(q & m, e);
	endtask : rd
	task automatic unlock();
		wr(KEY, {16'h0000, `MPF_KEY_FIRST});
		wr(KEY, {16'h0000, `MPF_KEY_SECOND});
	endtask : unlock
	task automatic final_report();
		if (err_total == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : final_report
	initial begin
		repeat (4000) @(posedge clk);
		err_total++;
		final_report();
	end
	initial begin
		repeat (4) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		rd(`MPF_OFF_CTRL, ALL, `MPF_CTRL_RESET);
		rd(STA, 32'h0000_0010, 32'h0000_0010);
		rd(FC0, ALL, `MPF_FC_RESET);
		rd(8'hFC, ALL, 32'h0000_0000);
		wr(OC0, 32'h0000_0003);
		rd(OC0, ALL, 32'h0000_0000);
		wr(FC0, 32'h0000_001D);
		rd(FC0, ALL, (`MPF_FC_RESET & 32'hFFFF_FFFC) | 32'h0000_0001);
		wr(STA, 32'h0000_0008);
		rd(STA, 32'h0000_0010, 32'h0000_0010);
		trip <= 1'b0;
		repeat (4) @(posedge clk);
		wr(STA, 32'h0000_0008);
		rd(STA, 32'h0000_0010, 32'h0000_0000);
		wr(KEY, {16'h0000, `MPF_KEY_FIRST});
		rd(STA, 32'h0000_0020, 32'h0000_0000);
		wr(KEY, {16'h0000, `MPF_KEY_SECOND});
		wr(OC0, 32'h0000_0003);
		rd(OC0, ALL, 32'h0000_0000);
		unlock();
		rd(STA, 32'h0000_0020, 32'h0000_0020);
		wr(OC0, 32'h0000_0003);
		rd(OC0, ALL, 32'h0000_0000);
		unlock();
		wr(OC0, 32'h0000_0003);
		wr(OC0, 32'h0000_0007);
		rd(OC0, ALL, 32'h0000_0003);
		unlock();
		wr(FC0, 32'h0000_0001);
		rd(FC0, ALL, 32'h0000_0001);
		wr(G0, 32'h0000_0013);
		wr(G0 + `MPF_GOFF_DUTY, 32'h0000_000A);
		wr(G0 + `MPF_GOFF_TRIG, 32'h0000_0005);
		wr(`MPF_OFF_MTPER, 32'h0000_0013);
		wr(`MPF_OFF_SEVCMP, 32'h0000_0005);
		wr(`MPF_OFF_CTRL, 32'h0000_0007);
		wr(OC0 + 8'h20, 32'h0000_0003);
		rd(OC0 + 8'h20, ALL, 32'h0000_0003);
		sync_req <= 1'b1;
		repeat (3) @(posedge clk);
		sync_req <= 1'b0;
		ph = 2'b00;
		repeat (200) begin
			@(posedge clk);
			nt += trig[0];
			n1 += trig[1];
			nv += sev;
			ns += sync_out;
			if (trig[0]) ph = {pins.high[0], pins.low[0]};
		end
		chk(32'(nt inside {[9:11]}), 32'h0000_0001);
		chk(32'(n1 inside {[9:11]}), 32'h0000_0001);
		chk(32'(nv inside {[9:11]}), 32'h0000_0001);
		chk(32'(ns inside {[9:11]}), 32'h0000_0001);
		chk(32'(rises > 4), 32'h0000_0001);
		chk(32'(ph), 32'h0000_0002);
		unlock();
		wr(OC0, 32'h0000_0007);
		ph = 2'b00;
		repeat (40) begin
			@(posedge clk);
			if (trig[0]) ph = {pins.high[0], pins.low[0]};
		end
		chk(32'(ph), 32'h0000_0001);
		flt <= 4'h1;
		repeat (4) @(posedge clk);
		acc = 2'b00;
		repeat (40) begin
			@(posedge clk);
			acc |= {pins.high[0], pins.low[0]};
		end
		chk(32'(acc), 32'h0000_0000);
		final_report();
	end
endmodule : tb
